/* File: common/ocd_consts.svh */
// constants for the over-current latch and power-up diagnosis block
// assumes a 100 MHz system clock; included by the filter and the core
`ifndef OCD_CONSTS_SVH
`define OCD_CONSTS_SVH
`define OCD_CLK_MHZ 100
`define OCD_FILT_NS 1000
`define OCD_FILT_CYC ((`OCD_FILT_NS * `OCD_CLK_MHZ) / 1000)
`define OCD_SETTLE_CYC 16
`define OCD_RETRY_CYC 30000000
`define OCD_NUM_OC 8
`define OCD_NUM_DET 6
`endif

/* File: common/ocd_pkg.sv */
// types for the over-current latch and diagnosis block
// shared by the top module and the filter leaf
package ocd_pkg;
  // gray sequence along the power-up path
  typedef enum logic [2:0] {
    OCD_FAULT_FLAG_PIN_T1 = 3'b000,
    OCD_FAULT_FLAG_PIN_T2 = 3'b001,
    OCD_FAULT_FLAG_PIN_T3 = 3'b011,
    OCD_RUN = 3'b010,
    OCD_TRIP = 3'b110,
    OCD_FAIL = 3'b111
  } ocd_state_t;
endpackage

/* File: common/ocd_filt_if.sv */
// carrier between the top and the qualification filter
// one clock domain, same clock as the top
`timescale 1ns/100ps
interface ocd_filt_if;
  logic [7:0] raw;
  logic armed;
  logic [7:0] hit;
  modport top (output raw, output armed, input hit);
  modport filt (input raw, input armed, output hit);
endinterface

/* File: src/ocd_filter.sv */
// short-circuit qualification filter, one counter per detector
// inputs are already synchronised by the top
`timescale 1ns/100ps
`include "ocd_consts.svh"
module ocd_filter
  import ocd_pkg::*;
#(
  parameter int FILT_CYC = `OCD_FILT_CYC
)
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  ocd_filt_if.filt f
);
  logic [7:0][7:0] cnt;
  logic [7:0][7:0] next_cnt;
  logic [7:0] next_hit;
  // count while current stays above threshold; any dip restarts (noise reject)
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      next_cnt[i] = cnt[i];
      next_hit[i] = 1'b0;
      if (!f.armed || !f.raw[i])
        next_cnt[i] = 8'h00;
      else if (cnt[i] == 8'(FILT_CYC - 1))
        next_hit[i] = 1'b1;
      else
        next_cnt[i] = cnt[i] + 8'h01;
    end
  end
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      cnt <= '0;
      f.hit <= '0;
    end
    else
    begin
      cnt <= next_cnt;
      f.hit <= next_hit;
    end
  end
  // a one-cycle blip must never qualify
  chk_filter_min_len: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    f.hit[0] |-> $past(f.raw[0], 2) && $past(f.raw[0], 1))
    else $error("trip qualified without sustained overcurrent");
endmodule

/* File: src/ocd_core.sv */
// over-current latch, fault pin control and power-up comparator check
// pins are asynchronous and pass a three-stage synchroniser
`timescale 1ns/100ps
`include "ocd_consts.svh"
module ocd_core
  import ocd_pkg::*;
#(
  parameter int FILT_CYC = `OCD_FILT_CYC,
  parameter int SETTLE_CYC = `OCD_SETTLE_CYC,
  parameter int RETRY_CYC = `OCD_RETRY_CYC
)
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_run_gate_pin,
  input wire logic i_run_gate_inverted_pin,
  input wire logic [7:0] i_oc_raw,
  input wire logic [5:0] i_det_raw,
  input wire logic i_mode_auto,
  input wire logic i_spi_cancel,
  output logic o_fault_flag_pin,
  output logic o_drive_enable,
  output logic [5:0] o_thr_fault_flag_pin,
  output logic [7:0] o_oc_flag,
  output logic o_fault_flag_pin_fail
);
  ocd_filt_if fi();
  ocd_state_t state;
  ocd_state_t next_state;
  logic [2:0] s_en;
  logic [2:0] s_enb;
  logic [2:0][7:0] s_oc;
  logic [2:0][5:0] s_det;
  logic [7:0] settle;
  logic [7:0] next_settle;
  logic [7:0] next_oc_flag;
  logic next_fault;
  logic next_fail;
  logic en_rise;
  logic en_fall;
  logic enb_rise;
  logic enb_fall;
  logic restart;
  logic release_fault;
  logic en_lvl;
  logic enb_lvl;
  logic [7:0] oc_lvl;
  logic next_en_lvl;
  logic next_enb_lvl;
  logic [7:0] next_oc_lvl;
  logic [24:0] retry;
  logic [24:0] next_retry;
  // three-stage synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      // reset to the idle pin levels so no false edge follows reset
      s_en <= 3'h7;
      s_enb <= 3'h0;
      s_oc <= '0;
      s_det <= '0;
      en_lvl <= 1'b1;
      enb_lvl <= 1'b0;
      oc_lvl <= 8'h00;
    end
    else
    begin
      s_en <= {s_en[1:0], i_run_gate_pin};
      s_enb <= {s_enb[1:0], i_run_gate_inverted_pin};
      s_oc <= {s_oc[1:0], i_oc_raw};
      s_det <= {s_det[1:0], i_det_raw};
      en_lvl <= next_en_lvl;
      enb_lvl <= next_enb_lvl;
      oc_lvl <= next_oc_lvl;
    end
  end
  // a level moves only once stages 1 and 2 agree; a one-stage blip is held off
  always_comb
  begin
    next_en_lvl = (s_en[1] == s_en[2]) ? s_en[2] : en_lvl;
    next_enb_lvl = (s_enb[1] == s_enb[2]) ? s_enb[2] : enb_lvl;
    next_oc_lvl = (s_oc[1] & s_oc[2]) | (oc_lvl & (s_oc[1] | s_oc[2]));
  end
  // edges are changes of the agreed level
  assign en_rise = next_en_lvl && !en_lvl;
  assign en_fall = !next_en_lvl && en_lvl;
  assign enb_rise = next_enb_lvl && !enb_lvl;
  assign enb_fall = !next_enb_lvl && enb_lvl;
  assign restart = en_fall || enb_rise || i_spi_cancel;
  assign release_fault = en_rise || enb_fall;
  // filter armed only while running so a held trip cannot retrigger
  assign fi.raw = oc_lvl;
  assign fi.armed = (state == OCD_RUN);
  ocd_filter #(
    .FILT_CYC(FILT_CYC)
  ) u_filt (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .f(fi.filt)
  );
  // power-up check, trip latch and fault pin
  always_comb
  begin
    next_state = state;
    next_settle = settle;
    next_oc_flag = o_oc_flag;
    next_fault = o_fault_flag_pin;
    next_fail = o_fault_flag_pin_fail;
    next_retry = 25'h000_0000;
    case (state)
      OCD_FAULT_FLAG_PIN_T1, OCD_FAULT_FLAG_PIN_T2, OCD_FAULT_FLAG_PIN_T3:
      begin
        next_fault = 1'b0;
        if (settle == 8'(SETTLE_CYC - 1))
        begin
          next_settle = 8'h00;
          // T1 threshold normal, T2 diagnostic, T3 normal again; both stages must agree
          if (state == OCD_FAULT_FLAG_PIN_T2 ? (s_det[1] != 6'h3f || s_det[2] != 6'h3f)
              : (s_det[1] != 6'h00 || s_det[2] != 6'h00))
            next_fail = 1'b1;
          if (state == OCD_FAULT_FLAG_PIN_T1)
            next_state = OCD_FAULT_FLAG_PIN_T2;
          else if (state == OCD_FAULT_FLAG_PIN_T2)
            next_state = OCD_FAULT_FLAG_PIN_T3;
          else if (next_fail)
            next_state = OCD_FAIL;
          else
          begin
            next_state = OCD_RUN;
            next_fault = 1'b1;
          end
        end
        else
          next_settle = settle + 8'h01;
      end
      OCD_RUN:
      begin
        if (fi.hit != 8'h00)
        begin
          // lowest index wins on a tie; later ones are locked out
          next_oc_flag = fi.hit & (~fi.hit + 8'h01);
          next_fault = 1'b0;
          next_state = OCD_TRIP;
        end
      end
      OCD_TRIP:
      begin
        // latch mode waits for a pulse; automatic mode retries after a hold-off
        if (restart)
        begin
          next_state = OCD_RUN;
          next_oc_flag = 8'h00;
        end
        else if (i_mode_auto && retry == 25'(RETRY_CYC - 1))
        begin
          next_state = OCD_RUN;
          next_oc_flag = 8'h00;
        end
        else if (i_mode_auto)
          next_retry = retry + 25'h000_0001;
      end
      default:
        next_fault = 1'b0;
    endcase
    if (release_fault && state != OCD_FAIL && !(state == OCD_RUN && fi.hit != 8'h00)
        && state != OCD_FAULT_FLAG_PIN_T1 && state != OCD_FAULT_FLAG_PIN_T2 && state != OCD_FAULT_FLAG_PIN_T3)
      next_fault = 1'b1;
  end
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      state <= OCD_FAULT_FLAG_PIN_T1;
      settle <= 8'h00;
      o_oc_flag <= 8'h00;
      o_fault_flag_pin <= 1'b0;
      o_fault_flag_pin_fail <= 1'b0;
      retry <= 25'h000_0000;
    end
    else
    begin
      state <= next_state;
      settle <= next_settle;
      o_oc_flag <= next_oc_flag;
      o_fault_flag_pin <= next_fault;
      o_fault_flag_pin_fail <= next_fail;
      retry <= next_retry;
    end
  end
  // all drivers off outside run, thresholds high only in the middle test
  assign o_drive_enable = (state == OCD_RUN);
  assign o_thr_fault_flag_pin = (state == OCD_FAULT_FLAG_PIN_T2) ? 6'h3f : 6'h00;
  sequence s_trip;
    state == OCD_RUN && fi.hit != 8'h00;
  endsequence
  chk_trip_drive_off: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    s_trip |=> !o_drive_enable && !o_fault_flag_pin)
    else $error("trip did not cut drivers and fault pin together");
  chk_single_flag: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    state == OCD_TRIP |-> $onehot(o_oc_flag))
    else $error("more than one overcurrent flag set");
  chk_latch_hold: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    state == OCD_TRIP && !restart && !i_mode_auto |=> state == OCD_TRIP)
    else $error("latched trip left without restart");
  chk_restart_run: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    state == OCD_TRIP && restart |=> o_drive_enable)
    else $error("restart did not resume drive");
  chk_fault_release: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    release_fault && state == OCD_TRIP |=> o_fault_flag_pin)
    else $error("fault pin not released by gate edge");
  chk_fault_flag_pin_thresh: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    state == OCD_FAULT_FLAG_PIN_T2 |-> o_thr_fault_flag_pin == 6'h3f && !o_drive_enable)
    else $error("diagnostic threshold not applied");
  chk_run_thresh: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    state == OCD_RUN |-> o_thr_fault_flag_pin == 6'h00)
    else $error("normal threshold not applied in run");
  chk_fault_flag_pin_fault_low: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    state == OCD_FAIL |-> !o_fault_flag_pin && o_fault_flag_pin_fail)
    else $error("failed diagnosis released fault pin");
  chk_fault_flag_pin_order: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    state == OCD_FAULT_FLAG_PIN_T1 && next_state != OCD_FAULT_FLAG_PIN_T1 |=> state == OCD_FAULT_FLAG_PIN_T2)
    else $error("diagnosis step skipped");
  // automatic mode must hand drive back once the hold-off has run out
  chk_auto_retry: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    state == OCD_TRIP && i_mode_auto && retry == 25'(RETRY_CYC - 1) |=> o_drive_enable)
    else $error("automatic retry did not resume drive");
  // drivers off and fault pin low for the whole diagnosis
  chk_fault_flag_pin_outputs_off: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (state == OCD_FAULT_FLAG_PIN_T1 || state == OCD_FAULT_FLAG_PIN_T2 || state == OCD_FAULT_FLAG_PIN_T3)
      |-> !o_drive_enable && !o_fault_flag_pin)
    else $error("diagnosis released drivers or fault pin");
endmodule

/* File: bench/ocd_mcu_model.sv */
// controller-side model: gate pin pulses on request, detector answers
// assumes the core's clock; requests are one-cycle strobes
`timescale 1ns/100ps
module ocd_mcu_model
(
  input wire logic i_clk_sys,
  input wire logic i_pulse_gate,
  input wire logic i_pulse_inv,
  input wire logic [5:0] i_thr_fault_flag_pin,
  input wire logic [5:0] i_det_flip,
  output logic o_run_gate_pin,
  output logic o_run_gate_inverted_pin,
  output logic [5:0] o_det_raw
);
  // at normal supply each detector follows its threshold select
  assign o_det_raw = i_thr_fault_flag_pin ^ i_det_flip;
  initial
  begin
    o_run_gate_pin = 1'b1;
    o_run_gate_inverted_pin = 1'b0;
  end
  // pulses outlast the three-flop sync, so each edge is seen
  always @(posedge i_clk_sys)
  begin
    if (i_pulse_gate)
    begin
      @(negedge i_clk_sys) o_run_gate_pin <= 1'b0;
      repeat (6) @(negedge i_clk_sys);
      o_run_gate_pin <= 1'b1;
    end
  end
  // inverted gate: rise restarts, fall releases the fault pin
  always @(posedge i_clk_sys)
  begin
    if (i_pulse_inv)
    begin
      @(negedge i_clk_sys) o_run_gate_inverted_pin <= 1'b1;
      repeat (6) @(negedge i_clk_sys);
      o_run_gate_inverted_pin <= 1'b0;
    end
  end
endmodule

/* File: bench/ocd_core_tb_top.sv */
// self-checking bench for the over-current latch and diagnosis core
// shortened filter and settle counts; inputs change on falling edges
`timescale 1ns/100ps
module ocd_core_tb_top;
  localparam int FILT = 4;
  localparam int SETTLE = 4;
  localparam int RETRY = 24;
  logic mode = 1'b0;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic [7:0] oc = 8'h00;
  logic cancel = 1'b0;
  logic pg = 1'b0;
  logic pi = 1'b0;
  logic [5:0] flip = 6'h00;
  logic gate, gate_n, fault, en, dfail;
  logic [5:0] det, thr;
  logic [7:0] flag;
  int errors = 0;
  int cmp_count = 0;
  ocd_core #(.FILT_CYC(FILT), .SETTLE_CYC(SETTLE), .RETRY_CYC(RETRY)) u_dut (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset), .i_run_gate_pin(gate), .i_run_gate_inverted_pin(gate_n),
    .i_oc_raw(oc), .i_det_raw(det), .i_mode_auto(mode),
    .i_spi_cancel(cancel), .o_fault_flag_pin(fault), .o_drive_enable(en),
    .o_thr_fault_flag_pin(thr), .o_oc_flag(flag), .o_fault_flag_pin_fail(dfail));
  ocd_mcu_model u_mcu (.i_clk_sys(i_clk_sys), .i_pulse_gate(pg), .i_pulse_inv(pi),
    .i_thr_fault_flag_pin(thr), .i_det_flip(flip), .o_run_gate_pin(gate),
    .o_run_gate_inverted_pin(gate_n), .o_det_raw(det));
  initial
  begin
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("FAIL %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask
  // bounded wait for drive enable; returns cycles taken
  task automatic wait_en(input logic val, output int n);
    n = 0;
    while (en !== val)
    begin
      @(negedge i_clk_sys);
      n++;
      if (n > 40)
      begin
        chk("drive_enable wait", {7'h00, val}, {7'h00, en});
        end_sim();
      end
    end
  endtask
  task automatic do_reset();
    int k;
    int seen;
    i_reset = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    i_reset = 1'b0;
    seen = 0;
    // diagnosis window: outputs held off, fault low
    // three steps; at the last cycle of the step count the core is already in run
    for (k = 0; k < 3 * SETTLE - 1; k++)
    begin
      @(negedge i_clk_sys);
      if (thr === 6'h3f) seen++;
      chk("fault_flag_pin fault_pin", 8'h00, {7'h00, fault});
      chk("fault_flag_pin drive_enable", 8'h00, {7'h00, en});
    end
    chk("fault_flag_pin thr_high seen", 8'h01, {7'h00, seen > 0});
  endtask
  task automatic t_fault_flag_pin_pass();
    int n;
    do_reset();
    wait_en(1'b1, n);
    chk("pass fault_pin", 8'h01, {7'h00, fault});
    chk("pass fault_flag_pin_fail", 8'h00, {7'h00, dfail});
    chk("run thr", 8'h00, {2'b00, thr});
  endtask
  // glitch shorter than the filter, then a held trip with a later second bit
  task automatic t_trip(input int idx);
    int n;
    oc[idx] = 1'b1;
    repeat (FILT - 1) @(negedge i_clk_sys);
    oc[idx] = 1'b0;
    repeat (10) @(negedge i_clk_sys);
    chk("glitch drive_enable", 8'h01, {7'h00, en});
    oc[idx] = 1'b1;
    wait_en(1'b0, n);
    chk("trip delay ok", 8'h01, {7'h00, n >= FILT && n <= FILT + 6});
    chk("trip fault_pin", 8'h00, {7'h00, fault});
    oc[7] = 1'b1;
    repeat (FILT + 6) @(negedge i_clk_sys);
    chk("first flag", 8'h01 << idx, flag);
    oc = 8'h00;
  endtask
  task automatic t_restart(input int how);
    int n;
    // latch mode must still be off well past the automatic hold-off
    repeat (RETRY) @(negedge i_clk_sys);
    chk("latched drive_enable", 8'h00, {7'h00, en});
    if (how == 0) pg = 1'b1;
    if (how == 1) pi = 1'b1;
    if (how == 2) cancel = 1'b1;
    @(negedge i_clk_sys);
    {pg, pi, cancel} = 3'b000;
    wait_en(1'b1, n);
    chk("restart flags", 8'h00, flag);
    repeat (14) @(negedge i_clk_sys);
    chk("released fault_pin", {7'h00, how != 2}, {7'h00, fault});
  endtask
  // automatic mode: the trip clears itself after the hold-off, no pulse needed
  task automatic t_auto();
    int n;
    mode = 1'b1;
    t_trip(3);
    wait_en(1'b1, n);
    chk("retry wait", 8'h01, {7'h00, n == RETRY - FILT - 6});
    chk("retry flags", 8'h00, flag);
    mode = 1'b0;
  endtask
  task automatic t_fault_flag_pin_fault();
    flip = 6'h04;
    do_reset();
    repeat (20) @(negedge i_clk_sys);
    chk("fail fault_flag_pin_fail", 8'h01, {7'h00, dfail});
    chk("fail fault_pin", 8'h00, {7'h00, fault});
    chk("fail drive_enable", 8'h00, {7'h00, en});
  endtask
  initial
  begin
    t_fault_flag_pin_pass();
    t_trip(2);
    t_restart(0);
    t_trip(0);
    t_restart(2);
    t_trip(5);
    t_restart(1);
    t_auto();
    t_fault_flag_pin_fault();
    end_sim();
  end
endmodule
